/* shared/aomr_cfg.svh */
// Constants for the audio offset mixer and resampler block
// Functional notes
// RL1: Offset sample 20 bits, high and low registers
// RL2: Offset config: underrun14, full13, enable12, rate11:0
// RL3: Fetch without full flag sets underrun
// RL4: Full set on writes, cleared on fetch
// RL5: Offset mixing only while enabled
// RL6: Offset fetch every rate plus one cycles
// RL7: Offset interrupt request on each fetch
// RL8: Mixed sum saturates to 20-bit signed
// RL9: Software keeps mix below 75% scale
// RL10: Resampler 24-bit in and out, no filter
// RL11: Output valid after 19 input samples
// RL12: Resampler sample high sixteen, low eight
// RL13: Resampler config: overrun15, rfull14, lfull13, enable12
// RL14: Update with unread data sets overrun
// RL15: Channel full set on write, cleared on read
// RL16: Resampler runs only while enabled
// RL17: Output every twice interval plus one cycles
// RL18: Resampler interrupt request on each store
// RL19: Disabled or underrun offset contributes zero
// RL20: Tick captures latest input pair, held
`ifndef AOMR_CFG_SVH
`define AOMR_CFG_SVH
// ==========================================================
// Register word indices, byte address is four times index
`define AOMR_IDX_OFS_CFG 16'hFEC1
`define AOMR_IDX_OFS_LLO 16'hFEC2
`define AOMR_IDX_OFS_LHI 16'hFEC3
`define AOMR_IDX_OFS_RLO 16'hFEC4
`define AOMR_IDX_OFS_RHI 16'hFEC5
`define AOMR_IDX_RS_CFG  16'hFEC6
`define AOMR_IDX_RS_LLO  16'hFEC7
`define AOMR_IDX_RS_LHI  16'hFEC8
`define AOMR_IDX_RS_RLO  16'hFEC9
`define AOMR_IDX_RS_RHI  16'hFECA
// ==========================================================
// Field positions
`define AOMR_BIT_ORUN   15
`define AOMR_BIT_URUN   14
`define AOMR_BIT_RFULL  14
`define AOMR_BIT_FULL   13
`define AOMR_BIT_LFULL  13
`define AOMR_BIT_ENA    12
`define AOMR_LO4_MSB    15
`define AOMR_LO4_LSB    12
`define AOMR_LO8_MSB    15
`define AOMR_LO8_LSB    8
// ==========================================================
// Values and counts
`define AOMR_REG_RST    16'h0000
`define AOMR_SAT_MAX    20'h7_FFFF
`define AOMR_SAT_MIN    20'h8_0000
`define AOMR_WARMUP     5'h13
`define AOMR_HTRANS_NSQ 2'h2
`define AOMR_HSIZE_WORD 3'h2
`endif

/* shared/aomr_pkg.sv */
// Types shared by the audio offset mixer and resampler block
package aomr_pkg;
    // Stereo sample pair of a given width
    typedef struct packed {
        logic [23:0] left;
        logic [23:0] right;
    } aomr_pair24_t;
    typedef struct packed {
        logic [19:0] left;
        logic [19:0] right;
    } aomr_pair20_t;
    // Latched AHB address phase
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] idx;
    } aomr_aphase_t;
endpackage : aomr_pkg

/* verilog/aomr_top.sv */
// Offset mixer and filterless resampler with AHB-Lite register slave
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ns
`include "aomr_cfg.svh"
module aomr_top (
    input  wire logic                  CLK,
    input  wire logic                  RST_B,
    input  wire logic                  HSEL,
    input  wire logic [31:0]           HADDR,
    input  wire logic [1:0]            HTRANS,
    input  wire logic                  HWRITE,
    input  wire logic [2:0]            HSIZE,
    input  wire logic [31:0]           HWDATA,
    input  wire logic                  HREADY,
    output logic      [31:0]           HRDATA,
    output logic                       HREADYOUT,
    output logic                       HRESP,
    input  wire aomr_pkg::aomr_pair24_t DAC_IN,
    input  wire logic                  DAC_IN_STB,
    input  wire aomr_pkg::aomr_pair20_t MIX_IN,
    output aomr_pkg::aomr_pair20_t      MIX_OUT,
    output logic                       OFS_IRQ,
    output logic                       RS_IRQ,
    output logic                       RS_VALID
);
    // ==========================================================
    // Bus slave
    aomr_pkg::aomr_aphase_t ap_r;
    logic [15:0] ofs_cfg_r;       // bits 11:0 rate, 12 enable
    logic        ofs_full_r;
    logic        ofs_urun_r;
    logic [15:0] ofs_llo_r;
    logic [15:0] ofs_lhi_r;
    logic [15:0] ofs_rlo_r;
    logic [15:0] ofs_rhi_r;
    logic        ofs_lw_r;        // left high written since fetch
    logic        ofs_rw_r;
    logic [15:0] rs_cfg_r;
    logic        rs_orun_r;
    logic        rs_lfull_r;
    logic        rs_rfull_r;
    aomr_pkg::aomr_pair24_t rs_out_r;
    logic        wr_en;
    logic        rd_en;
    logic [15:0] wd;
    logic [15:0] rd_nxt;
    logic        ofs_tick;
    logic        rs_tick;

    // Word index decode: byte address is four times index
    // Indices sit above 0x3FFF, so the full sixteen-bit index is compared
    function automatic logic hit(input logic [15:0] idx, input logic [15:0] ref_idx);
        hit = (idx == ref_idx);
    endfunction : hit

    // Address phase latch, only whole-word NONSEQ transfers
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ap_r <= '0;
        end else if (HREADY) begin
            ap_r.valid <= HSEL && (HTRANS == `AOMR_HTRANS_NSQ) && (HSIZE == `AOMR_HSIZE_WORD);
            ap_r.write <= HWRITE;
            ap_r.idx   <= HADDR[17:2];
        end
    end

    assign wr_en = ap_r.valid && ap_r.write;
    assign rd_en = ap_r.valid && !ap_r.write;
    assign wd    = HWDATA[15:0];

    // Zero wait states; always OKAY
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end
    end

    // Read mux; unmapped reads as zero
    always_comb begin
        rd_nxt = `AOMR_REG_RST;
        if (hit(HADDR[17:2], `AOMR_IDX_OFS_CFG)) begin
            rd_nxt = {1'b0, ofs_urun_r, ofs_full_r, ofs_cfg_r[12:0]}; // RL2
        end else if (hit(HADDR[17:2], `AOMR_IDX_OFS_LLO)) begin
            rd_nxt = {ofs_llo_r[15:12], 12'h000};                      // RL1
        end else if (hit(HADDR[17:2], `AOMR_IDX_OFS_LHI)) begin
            rd_nxt = ofs_lhi_r;
        end else if (hit(HADDR[17:2], `AOMR_IDX_OFS_RLO)) begin
            rd_nxt = {ofs_rlo_r[15:12], 12'h000};
        end else if (hit(HADDR[17:2], `AOMR_IDX_OFS_RHI)) begin
            rd_nxt = ofs_rhi_r;
        end else if (hit(HADDR[17:2], `AOMR_IDX_RS_CFG)) begin
            rd_nxt = {rs_orun_r, rs_rfull_r, rs_lfull_r, rs_cfg_r[12:0]}; // RL13
        end else if (hit(HADDR[17:2], `AOMR_IDX_RS_LLO)) begin
            rd_nxt = {rs_out_r.left[7:0], 8'h00};                      // RL12
        end else if (hit(HADDR[17:2], `AOMR_IDX_RS_LHI)) begin
            rd_nxt = rs_out_r.left[23:8];
        end else if (hit(HADDR[17:2], `AOMR_IDX_RS_RLO)) begin
            rd_nxt = {rs_out_r.right[7:0], 8'h00};
        end else if (hit(HADDR[17:2], `AOMR_IDX_RS_RHI)) begin
            rd_nxt = rs_out_r.right[23:8];
        end
    end

    // Read data registered in the address phase, stands in data phase
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            HRDATA <= 32'h0000_0000;
        end else if (HREADY && HSEL && !HWRITE && HTRANS == `AOMR_HTRANS_NSQ) begin
            HRDATA <= {16'h0000, rd_nxt};
        end
    end

    // ==========================================================
    // Offset path registers
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ofs_cfg_r <= `AOMR_REG_RST;
            ofs_llo_r <= `AOMR_REG_RST;
            ofs_lhi_r <= `AOMR_REG_RST;
            ofs_rlo_r <= `AOMR_REG_RST;
            ofs_rhi_r <= `AOMR_REG_RST;
        end else if (wr_en) begin
            if (hit(ap_r.idx, `AOMR_IDX_OFS_CFG)) begin
                ofs_cfg_r <= {3'h0, wd[12:0]};                      // RL2
            end else if (hit(ap_r.idx, `AOMR_IDX_OFS_LLO)) begin
                ofs_llo_r <= {wd[`AOMR_LO4_MSB:`AOMR_LO4_LSB], 12'h000}; // RL1
            end else if (hit(ap_r.idx, `AOMR_IDX_OFS_LHI)) begin
                ofs_lhi_r <= wd;                                    // RL1
            end else if (hit(ap_r.idx, `AOMR_IDX_OFS_RLO)) begin
                ofs_rlo_r <= {wd[`AOMR_LO4_MSB:`AOMR_LO4_LSB], 12'h000};
            end else if (hit(ap_r.idx, `AOMR_IDX_OFS_RHI)) begin
                ofs_rhi_r <= wd;
            end
        end
    end

    // Rate divider; counter restarts while disabled
    logic [11:0] ofs_cnt_r;
    always_ff @(posedge CLK) begin
        if (!RST_B || !ofs_cfg_r[`AOMR_BIT_ENA]) begin
            ofs_cnt_r <= 12'h000;                                    // RL5
        end else if (ofs_cnt_r >= ofs_cfg_r[11:0]) begin
            ofs_cnt_r <= 12'h000;                                    // RL6
        end else begin
            ofs_cnt_r <= ofs_cnt_r + 12'h001;
        end
    end
    assign ofs_tick = ofs_cfg_r[`AOMR_BIT_ENA] && (ofs_cnt_r >= ofs_cfg_r[11:0]);

    // Full needs both high words written; fetch clears, a write in the same cycle wins
    logic ofs_lw_set;
    logic ofs_rw_set;
    assign ofs_lw_set = wr_en && hit(ap_r.idx, `AOMR_IDX_OFS_LHI);
    assign ofs_rw_set = wr_en && hit(ap_r.idx, `AOMR_IDX_OFS_RHI);
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ofs_lw_r <= 1'b0;
            ofs_rw_r <= 1'b0;
        end else begin
            ofs_lw_r <= ofs_lw_set || (ofs_lw_r && !ofs_tick);
            ofs_rw_r <= ofs_rw_set || (ofs_rw_r && !ofs_tick);
        end
    end
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ofs_full_r <= 1'b0;
        end else if ((ofs_lw_r || ofs_lw_set) && (ofs_rw_r || ofs_rw_set)
                     && (ofs_lw_set || ofs_rw_set)) begin
            ofs_full_r <= 1'b1;                                      // RL4
        end else if (ofs_tick) begin
            ofs_full_r <= 1'b0;                                      // RL4
        end
    end

    // Underrun sticky; software write of zero to bit 14 clears, set wins
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ofs_urun_r <= 1'b0;
        end else if (ofs_tick && !ofs_full_r) begin
            ofs_urun_r <= 1'b1;                                      // RL3
        end else if (wr_en && hit(ap_r.idx, `AOMR_IDX_OFS_CFG)) begin
            ofs_urun_r <= wd[`AOMR_BIT_URUN];
        end
    end

    // Fetched offset pair; zero when disabled or underrun
    aomr_pkg::aomr_pair20_t ofs_cur_r;
    always_ff @(posedge CLK) begin
        if (!RST_B || !ofs_cfg_r[`AOMR_BIT_ENA]) begin
            ofs_cur_r <= '0;                                         // RL19
        end else if (ofs_tick) begin
            if (ofs_full_r) begin
                ofs_cur_r.left  <= {ofs_lhi_r, ofs_llo_r[15:12]};    // RL1
                ofs_cur_r.right <= {ofs_rhi_r, ofs_rlo_r[15:12]};
            end else begin
                ofs_cur_r <= '0;                                     // RL19
            end
        end
    end

    // Offset fetch interrupt, one-cycle pulse for nonzero rate, held high at rate zero
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            OFS_IRQ <= 1'b0;
        end else begin
            OFS_IRQ <= ofs_tick;                                     // RL7
        end
    end

    // Saturating add; sign-extended 21-bit sum clamps instead of wrapping
    function automatic logic [19:0] sat_add(input logic [19:0] a, input logic [19:0] b);
        logic [20:0] s;
        s = {a[19], a} + {b[19], b};
        if (s[20] != s[19]) begin
            sat_add = s[20] ? `AOMR_SAT_MIN : `AOMR_SAT_MAX;         // RL8
        end else begin
            sat_add = s[19:0];
        end
    endfunction : sat_add

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            MIX_OUT <= '0;
        end else begin
            MIX_OUT.left  <= sat_add(MIX_IN.left, ofs_cur_r.left);   // RL8
            MIX_OUT.right <= sat_add(MIX_IN.right, ofs_cur_r.right);
        end
    end

    // ==========================================================
    // Resampler configuration
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            rs_cfg_r <= `AOMR_REG_RST;
        end else if (wr_en && hit(ap_r.idx, `AOMR_IDX_RS_CFG)) begin
            rs_cfg_r <= {3'h0, wd[12:0]};                            // RL13
        end
    end

    // Half-rate divider: tick every 2*(interval+1) cycles
    logic [12:0] rs_cnt_r;
    always_ff @(posedge CLK) begin
        if (!RST_B || !rs_cfg_r[`AOMR_BIT_ENA]) begin
            rs_cnt_r <= 13'h0000;                                    // RL16
        end else if (rs_tick) begin
            rs_cnt_r <= 13'h0000;
        end else begin
            rs_cnt_r <= rs_cnt_r + 13'h0001;
        end
    end
    assign rs_tick = rs_cfg_r[`AOMR_BIT_ENA]
                     && (rs_cnt_r >= {rs_cfg_r[11:0], 1'b1});        // RL17

    // Start-up count of input samples; valid after nineteen
    logic [4:0] warm_r;
    always_ff @(posedge CLK) begin
        if (!RST_B || !rs_cfg_r[`AOMR_BIT_ENA]) begin
            warm_r <= 5'h00;
        end else if (DAC_IN_STB && warm_r < `AOMR_WARMUP) begin
            warm_r <= warm_r + 5'h01;                                // RL11
        end
    end
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            RS_VALID <= 1'b0;
        end else begin
            RS_VALID <= (warm_r == `AOMR_WARMUP);                    // RL11
        end
    end

    // Latest input pair, held between strobes
    aomr_pkg::aomr_pair24_t rs_in_r;
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            rs_in_r <= '0;
        end else if (DAC_IN_STB) begin
            rs_in_r <= DAC_IN;                                       // RL10
        end
    end

    // Output capture: no filtering, plain sample and hold
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            rs_out_r <= '0;
        end else if (rs_tick) begin
            rs_out_r <= rs_in_r;                                     // RL20
        end
    end

    // Channel full: read of high word clears, new store wins
    logic rs_lrd;
    logic rs_rrd;
    assign rs_lrd = rd_en && hit(ap_r.idx, `AOMR_IDX_RS_LHI);
    assign rs_rrd = rd_en && hit(ap_r.idx, `AOMR_IDX_RS_RHI);
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            rs_lfull_r <= 1'b0;
            rs_rfull_r <= 1'b0;
        end else begin
            rs_lfull_r <= rs_tick || (rs_lfull_r && !rs_lrd);        // RL15
            rs_rfull_r <= rs_tick || (rs_rfull_r && !rs_rrd);        // RL15
        end
    end

    // Overrun sticky; cleared by writing zero to bit 15
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            rs_orun_r <= 1'b0;
        end else if (rs_tick && (rs_lfull_r || rs_rfull_r)) begin
            rs_orun_r <= 1'b1;                                       // RL14
        end else if (wr_en && hit(ap_r.idx, `AOMR_IDX_RS_CFG)) begin
            rs_orun_r <= wd[`AOMR_BIT_ORUN];
        end
    end

    // Store interrupt, one-cycle pulse
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            RS_IRQ <= 1'b0;
        end else begin
            RS_IRQ <= rs_tick;                                       // RL18
        end
    end
endmodule : aomr_top

/* tb/aomr_assertions.sv */
// Port-level checker for the offset mixer and resampler
`timescale 1ns/1ns
`include "aomr_cfg.svh"
module aomr_chk (
    input wire logic                   CLK,
    input wire logic                   RST_B,
    input wire logic                   HSEL,
    input wire logic [31:0]            HADDR,
    input wire logic [1:0]             HTRANS,
    input wire logic                   HWRITE,
    input wire logic                   HREADY,
    input wire logic [31:0]            HRDATA,
    input wire logic                   HREADYOUT,
    input wire logic                   HRESP,
    input wire logic                   DAC_IN_STB,
    input wire aomr_pkg::aomr_pair20_t MIX_OUT,
    input wire logic                   OFS_IRQ,
    input wire logic                   RS_IRQ,
    input wire logic                   RS_VALID
);
    // ==========================================================
    // Helper logic
    logic [7:0] stb_cnt_r;
    // Strobes since reset; saturates so it never wraps below the warm-up
    always_ff @(posedge CLK) begin
        if (!RST_B) stb_cnt_r <= 8'h00;
        else if (DAC_IN_STB && stb_cnt_r != 8'hFF) stb_cnt_r <= stb_cnt_r + 8'h01;
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    a_ready_always: assert property (HREADYOUT) else $error("hreadyout low");
    a_resp_okay: assert property (!HRESP) else $error("error response");
    a_rdata_upper: assert property (HRDATA[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_unmapped_zero: assert property (HSEL && HREADY && HTRANS == `AOMR_HTRANS_NSQ && !HWRITE
        && (HADDR[17:2] < `AOMR_IDX_OFS_CFG || HADDR[17:2] > `AOMR_IDX_RS_RHI)
        |=> HRDATA == 32'h0000_0000) else $error("unmapped read not zero");
    a_rs_irq_pulse: assert property (RS_IRQ |=> !RS_IRQ)
        else $error("resampler request longer than one cycle");
    a_valid_warmup: assert property ($rose(RS_VALID) |-> stb_cnt_r >= `AOMR_WARMUP)
        else $error("resampler valid too early");
    // Reset checks must run while reset is low, so they carry no disable
    a_reset_bus: assert property (disable iff (1'b0)
        !RST_B |=> HRDATA == 32'h0000_0000 && HREADYOUT && !HRESP) else $error("bus not reset");
    a_reset_outs: assert property (disable iff (1'b0)
        !RST_B |=> MIX_OUT == '0 && !OFS_IRQ && !RS_IRQ && !RS_VALID)
        else $error("outputs not reset");
endmodule : aomr_chk
bind aomr_top aomr_chk i_chk (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DAC_IN_STB(DAC_IN_STB), .MIX_OUT(MIX_OUT),
    .OFS_IRQ(OFS_IRQ), .RS_IRQ(RS_IRQ), .RS_VALID(RS_VALID));

/* tb/aomr_dac_model.sv */
// Model of the primary DAC path feeding the block
`timescale 1ns/1ns
module aomr_dac_model #(
    parameter int GAP = 4
) (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   run,
    input  wire aomr_pkg::aomr_pair20_t mix_set,
    output aomr_pkg::aomr_pair24_t      dac_in,
    output logic                        dac_in_stb,
    output aomr_pkg::aomr_pair20_t      mix_in
);
    int cnt;
    // New 24-bit pair with a one-cycle strobe every GAP cycles while running
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt        <= 0;
            dac_in_stb <= 1'b0;
            dac_in     <= '0;
        end else begin
            dac_in_stb <= 1'b0;
            if (run) begin
                cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
                if (cnt == GAP - 1) begin
                    dac_in_stb   <= 1'b1;
                    dac_in.left  <= dac_in.left + 24'h13_579B;
                    dac_in.right <= dac_in.left ^ 24'hFF_00FF;
                end
            end
        end
    end
    // Mix samples follow the bench; it keeps them within the headroom
    always_ff @(posedge clk) mix_in <= mix_set;
endmodule : aomr_dac_model

/* tb/aomr_tb_top.sv */
// Self-checking bench for the offset mixer and resampler
`timescale 1ns/1ns
`include "aomr_cfg.svh"
module aomr_tb_top;
    logic                   clk = 0, rst_b = 0, hsel = 0, hwrite = 0, run = 0;
    logic [31:0]            haddr = 0, hwdata = 0, hrdata, rd, seed = 32'he9b7_68a6;
    logic [1:0]             htrans = 0;
    logic [2:0]             hsize = 0;
    logic                   hreadyout, hresp, ofs_irq, rs_irq, rs_valid, stb;
    aomr_pkg::aomr_pair24_t dac_in;
    aomr_pkg::aomr_pair20_t mix_in, mix_set = '0, mix_out, ofs;
    int                     failures = 0, tests_run = 0, n, r, f;
    // ==========================================================
    // Clock, partner and design
    always #5 clk = ~clk;
    aomr_dac_model i_dac (.clk(clk), .rst_b(rst_b), .run(run), .mix_set(mix_set),
        .dac_in(dac_in), .dac_in_stb(stb), .mix_in(mix_in));
    aomr_top i_dut (.CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .DAC_IN(dac_in), .DAC_IN_STB(stb),
        .MIX_IN(mix_in), .MIX_OUT(mix_out), .OFS_IRQ(ofs_irq), .RS_IRQ(rs_irq),
        .RS_VALID(rs_valid));
    // ==========================================================
    // Helpers
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    // Clamp instead of wrap, as the mixer does
    function automatic logic [19:0] sat(input logic [19:0] a, input logic [19:0] b);
        logic [20:0] s;
        s = {a[19], a} + {b[19], b};
        if (s[20:19] == 2'b01) return `AOMR_SAT_MAX;
        if (s[20:19] == 2'b10) return `AOMR_SAT_MIN;
        return s[19:0];
    endfunction : sat
    task automatic summarize;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task automatic chk(input logic [47:0] got, input logic [47:0] e);
        tests_run++;
        if (got !== e) begin
            failures++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, e);
        end
    endtask : chk
    // One AHB single transfer; address held until taken, data until ready
    task automatic bus(input logic w, input logic [15:0] i, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= `AOMR_HTRANS_NSQ;
        hwrite <= w;
        hsize  <= `AOMR_HSIZE_WORD;
        haddr  <= {14'h0000, i, 2'b00};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rdc(input logic [15:0] i, input logic [31:0] e);
        bus(1'b0, i, 32'h0000_0000);
        chk(rd, e);
    endtask : rdc
    // Wait for 0 offset request, 1 resampler request, 2 valid; bounded
    task automatic wt(input int s, output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (!((s == 0) ? ofs_irq === 1'b1 : (s == 1) ? rs_irq === 1'b1
            : rs_valid === 1'b1) && c < 3000);
        if (c >= 3000) chk(48'(s), 48'hFFFF);
    endtask : wt
    task automatic wofs(input aomr_pkg::aomr_pair20_t v);
        bus(1'b1, `AOMR_IDX_OFS_LLO, {16'h0000, v.left[3:0], 12'h000});
        bus(1'b1, `AOMR_IDX_OFS_LHI, {16'h0000, v.left[19:4]});
        bus(1'b1, `AOMR_IDX_OFS_RLO, {16'h0000, v.right[3:0], 12'h000});
        bus(1'b1, `AOMR_IDX_OFS_RHI, {16'h0000, v.right[19:4]});
    endtask : wofs
    // Watchdog well beyond the thousand-odd cycles the run needs
    initial begin
        #200000;
        failures++;
        summarize();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        for (int k = 0; k < 10; k++) rdc(16'hFEC1 + 16'(k), 32'h0000_0000);
        rdc(16'hFEC0, 32'h0000_0000);
        // Random offsets and mix at a quarter of full scale keep headroom
        seed = nx(seed);
        ofs = {{2{seed[17]}}, seed[17:0], {2{seed[31]}}, seed[31:14]};
        seed = nx(seed);
        mix_set <= {{2{seed[17]}}, seed[17:0], {2{seed[31]}}, seed[31:14]};
        r = 63 + int'(seed[4:0]);
        wofs(ofs);
        rdc(`AOMR_IDX_OFS_LHI, {16'h0000, ofs.left[19:4]});
        rdc(`AOMR_IDX_OFS_RLO, {16'h0000, ofs.right[3:0], 12'h000});
        rdc(`AOMR_IDX_OFS_CFG, 32'h0000_2000);
        bus(1'b1, `AOMR_IDX_OFS_CFG, 32'h0000_1000 | r);
        wt(0, n);
        repeat (3) @(posedge clk);
        chk(mix_out, {sat(mix_in.left, ofs.left), sat(mix_in.right, ofs.right)});
        rdc(`AOMR_IDX_OFS_CFG, 32'h0000_1000 | r);
        wt(0, n);
        wt(0, n);
        chk(48'(n), 48'(r + 1));
        repeat (3) @(posedge clk);
        chk(mix_out, mix_in);
        rdc(`AOMR_IDX_OFS_CFG, 32'h0000_5000 | r);
        // Saturation both ways
        ofs = {`AOMR_SAT_MAX, `AOMR_SAT_MIN};
        mix_set <= {20'h4_0000, 20'hC_0000};
        wofs(ofs);
        bus(1'b1, `AOMR_IDX_OFS_CFG, 32'h0000_1000 | r);
        rdc(`AOMR_IDX_OFS_CFG, 32'h0000_3000 | r);
        wt(0, n);
        repeat (3) @(posedge clk);
        chk(mix_out, {`AOMR_SAT_MAX, `AOMR_SAT_MIN});
        bus(1'b1, `AOMR_IDX_OFS_CFG, 32'(r));
        // Held offset clears one edge after disable, the mix one edge later
        repeat (3) @(posedge clk);
        chk(mix_out, mix_in);
        // Resampler warm-up, rate, flags and captured data
        f = 30;
        bus(1'b1, `AOMR_IDX_RS_CFG, 32'h0000_1000 | f);
        run <= 1'b1;
        n = 0;
        for (int c = 0; c < 3000 && rs_valid !== 1'b1; c++) begin
            @(posedge clk);
            n += int'(stb === 1'b1);
        end
        chk(48'(n), 48'(`AOMR_WARMUP));
        wt(1, n);
        wt(1, n);
        chk(48'(n), 48'(2 * (f + 1)));
        run <= 1'b0;
        wt(1, n);
        wt(1, n);
        rdc(`AOMR_IDX_RS_CFG, 32'h0000_F000 | f);
        rdc(`AOMR_IDX_RS_LHI, {16'h0000, dac_in.left[23:8]});
        rdc(`AOMR_IDX_RS_LLO, {16'h0000, dac_in.left[7:0], 8'h00});
        rdc(`AOMR_IDX_RS_RHI, {16'h0000, dac_in.right[23:8]});
        rdc(`AOMR_IDX_RS_RLO, {16'h0000, dac_in.right[7:0], 8'h00});
        rdc(`AOMR_IDX_RS_CFG, 32'h0000_9000 | f);
        bus(1'b1, `AOMR_IDX_RS_CFG, 32'h0000_1000 | f);
        rdc(`AOMR_IDX_RS_CFG, 32'h0000_1000 | f);
        // Both disabled: no requests at all
        bus(1'b1, `AOMR_IDX_RS_CFG, 32'h0000_0000);
        n = 0;
        repeat (300) begin
            @(posedge clk);
            n += int'(ofs_irq !== 1'b0) + int'(rs_irq !== 1'b0);
        end
        chk(48'(n), 48'h0000);
        summarize();
    end
endmodule : aomr_tb_top
